// >>> include/sofc_pkg.sv
package sofc_pkg;

	// ==========================================================
	// Register map (byte addresses on APB)
	localparam logic [7:0]  ADDR_FETCH_CTL  = 8'h44;
	localparam logic [7:0]  ADDR_MGMT_AGT   = 8'h48;
	localparam logic [7:0]  ADDR_CMD_AGT    = 8'h4C;
	localparam logic [7:0]  ADDR_AGT_CTL    = 8'h50;

	// ==========================================================
	// Reset values
	localparam logic [31:0] FETCH_CTL_RST   = 32'h10080F00;
	localparam logic [31:0] MGMT_AGT_RST    = 32'h00004000;
	localparam logic [31:0] CMD_AGT_RST     = 32'h00000000;
	// Reserved bit 2 (word bit 29) reads zero and ignores writes
	localparam logic [31:0] FETCH_CTL_WMASK = 32'hDFFFFFFF;

	// ==========================================================
	// Field positions: bit 0 of the register is word bit 31
	localparam int MGMT_VALID_POS  = 31;
	localparam int MGMT_BUSY_POS   = 30;
	localparam int MGMT_SHORT_POS  = 28;
	localparam int MGMT_PRI_HI     = 27;
	localparam int MGMT_PRI_LO     = 24;
	localparam int CMD_LEN_HI      = 23;
	localparam int CMD_LEN_LO      = 16;
	localparam int CMD_VALID0_POS  = 15;
	localparam int AGT_SEL_HI      = 17;
	localparam int AGT_SEL_LO      = 16;
	localparam int NUM_AGENTS      = 4;

	// ==========================================================
	// Counts
	localparam logic [7:0]  MGMT_ORB_QUADS  = 8'h08;
	localparam logic [1:0]  SHORT_HDR_QUADS = 2'h3;

	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		TGT_MGMT    = 2'b00,
		TGT_ORB_PTR = 2'b01,
		TGT_OTHER   = 2'b10
	} sofc_target_t;

	typedef enum logic [3:0] {
		ACK_COMPLETE   = 4'h1,
		ACK_PENDING    = 4'h2,
		ACK_BUSY_X     = 4'h4,
		ACK_ADDR_ERROR = 4'h7
	} sofc_ack_t;

	// ==========================================================
	// State records
	typedef struct packed {
		logic [31:0] fetch_ctl;
		logic [31:0] mgmt_agt;
		logic [31:0] cmd_agt;
		logic [3:0]  assigned;
		logic [63:0] node_ids;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        resp_valid;
		logic [3:0]  resp_code;
		logic        fetch_valid;
		logic        fetch_cmd;
		logic [1:0]  fetch_agent;
		logic [3:0]  fetch_priority;
		logic [7:0]  fetch_length;
	} sofc_state_t;

	localparam sofc_state_t STATE_RST = '{
		fetch_ctl: FETCH_CTL_RST,
		mgmt_agt:  MGMT_AGT_RST,
		cmd_agt:   CMD_AGT_RST,
		resp_code: ACK_COMPLETE,
		default:   '0
	};

	typedef struct packed {
		logic [1:0]  cnt;
		logic        mgmt_wr;
		logic        cmd_wr;
		logic [31:0] data;
	} sofc_rx_state_t;

endpackage

// >>> hw/sofc_rx_format.sv
`timescale 1ns/1ps
module sofc_rx_format import sofc_pkg::*; (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Fetched quadlet stream
	input  wire logic        rx_valid,
	input  wire logic        rx_first,
	input  wire logic        rx_mgmt,
	input  wire logic [31:0] rx_data,
	input  wire logic        short_en,
	// Receive FIFO writes
	output logic             mgmt_wr,
	output logic             cmd_wr,
	output logic [31:0]      wr_data
);

	// ==========================================================
	// State
	sofc_rx_state_t st_r;
	sofc_rx_state_t st_nxt;
	logic [1:0]     idx;
	logic           drop;

	always_comb begin
		st_nxt         = st_r;
		idx            = rx_first ? 2'h0 : st_r.cnt;
		// Short format strips the leading header quadlets of the packet
		drop           = rx_mgmt && short_en && (idx < SHORT_HDR_QUADS);
		st_nxt.mgmt_wr = rx_valid && rx_mgmt && !drop;
		st_nxt.cmd_wr  = rx_valid && !rx_mgmt;
		if (rx_valid) begin
			st_nxt.data = rx_data;
			// Saturates: only the header window needs counting
			st_nxt.cnt  = (idx == SHORT_HDR_QUADS) ? idx : idx + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign mgmt_wr = st_r.mgmt_wr;
	assign cmd_wr  = st_r.cmd_wr;
	assign wr_data = st_r.data;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_short_drops_header;
		rx_valid && rx_first && rx_mgmt && short_en
			##1 rx_valid && !rx_first && rx_mgmt && short_en
			|=> !mgmt_wr;
	endproperty
	a_short_drops_header: assert property (p_short_drops_header)
		else $error("short format kept a header quadlet");

	property p_as_is_kept;
		rx_valid && rx_mgmt && !short_en |=> mgmt_wr && wr_data == $past(rx_data);
	endproperty
	a_as_is_kept: assert property (p_as_is_kept)
		else $error("as-is management quadlet not stored");

endmodule // sofc_rx_format

// >>> hw/sofc_fetch_control.sv
`timescale 1ns/1ps
// How it works
// - Reset to 1008_0F00h; bus reset keeps it
// - Management valid bit qualifies management agent register
// - Valid management block write starts ORB fetch
// - Management valid clear blocks management fetches
// - Busy management agent answers block writes with ack_busy_x
// - Short format strips header into management FIFO
// - Without short format store as is; survives
// - Management fetch request carries management priority
// - Command ORB length field sets fetch quadlets
// - Agent 0 valid bit qualifies command agent
// - Agent needs node ID assigned via 50h
// - ORB pointer block write fetches command ORB
// - Unassigned agent rejects every request
// - Agent valid clear makes agent offset invalid
// - Agents 1 to 3 alike, own bits
module sofc_fetch_control import sofc_pkg::*; (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB register port
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// Serial bus state
	input  wire logic          bus_reset,
	// Remote requests to the agents
	input  wire logic          req_valid,
	input  wire logic          req_block_write,
	input  wire sofc_target_t  req_target,
	input  wire logic [1:0]    req_agent,
	input  wire logic [15:0]   req_src_id,
	// Acknowledge back to the link
	output logic               resp_valid,
	output logic [3:0]         resp_code,
	// ORB fetch read requests
	output logic               fetch_valid,
	output logic               fetch_cmd,
	output logic [1:0]         fetch_agent,
	output logic [3:0]         fetch_priority,
	output logic [7:0]         fetch_length,
	// Fetched ORB quadlets
	input  wire logic          rx_valid,
	input  wire logic          rx_first,
	input  wire logic          rx_mgmt,
	input  wire logic [31:0]   rx_data,
	// Receive FIFO writes
	output logic               mgmt_rx_fifo_wr,
	output logic               cmd_rx_fifo_wr,
	output logic [31:0]        rx_fifo_data
);

	// ==========================================================
	// State and decode
	sofc_state_t st_r;
	sofc_state_t st_nxt;

	logic            apb_setup;
	logic            apb_wr;
	logic            mgmt_valid;
	logic            mgmt_busy;
	logic [3:0]      agent_ok;
	logic [3:0]      agent_valid;
	logic            mgmt_req;
	logic            cmd_req;

	assign apb_setup  = psel && !penable;
	// Writes land only at the edge the master sees pready
	assign apb_wr     = psel && penable && pwrite && st_r.pready;
	assign mgmt_valid = st_r.fetch_ctl[MGMT_VALID_POS];
	assign mgmt_busy  = st_r.fetch_ctl[MGMT_BUSY_POS];
	assign mgmt_req   = req_valid && req_target == TGT_MGMT;
	assign cmd_req    = req_valid && req_target != TGT_MGMT;

	// ==========================================================
	// Per-agent qualification
	for (genvar g = 0; g < NUM_AGENTS; g++) begin : g_agent
		assign agent_valid[g] = st_r.fetch_ctl[CMD_VALID0_POS - g];
		// Valid offset, assigned node ID and a matching source
		assign agent_ok[g]    = agent_valid[g] && st_r.assigned[g]
			&& req_src_id == st_r.node_ids[g*16 +: 16];
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt             = st_r;
		st_nxt.resp_valid  = 1'b0;
		st_nxt.fetch_valid = 1'b0;

		// APB: one wait-free access phase after each setup
		st_nxt.pready  = apb_setup;
		if (apb_setup) begin
			st_nxt.pslverr = 1'b0;
			case (paddr)
				ADDR_FETCH_CTL: st_nxt.prdata = st_r.fetch_ctl;
				ADDR_MGMT_AGT:  st_nxt.prdata = st_r.mgmt_agt;
				ADDR_CMD_AGT:   st_nxt.prdata = st_r.cmd_agt;
				ADDR_AGT_CTL:   st_nxt.prdata = {28'h0000000, st_r.assigned};
				default: begin
					st_nxt.prdata  = 32'h00000000;
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr) begin
			case (paddr)
				ADDR_FETCH_CTL: st_nxt.fetch_ctl = pwdata & FETCH_CTL_WMASK;
				ADDR_MGMT_AGT:  st_nxt.mgmt_agt  = pwdata;
				ADDR_CMD_AGT:   st_nxt.cmd_agt   = pwdata;
				ADDR_AGT_CTL: begin
					st_nxt.assigned[pwdata[AGT_SEL_HI:AGT_SEL_LO]] = 1'b1;
					st_nxt.node_ids[pwdata[AGT_SEL_HI:AGT_SEL_LO]*16 +: 16] =
						pwdata[15:0];
				end
				default: st_nxt.prdata = st_r.prdata;
			endcase
		end

		// Node IDs are renumbered on a bus reset; the control word is not
		if (bus_reset) begin
			st_nxt.assigned = 4'h0;
		end

		// Management agent requests
		if (mgmt_req) begin
			st_nxt.resp_valid = 1'b1;
			if (!mgmt_valid) begin
				st_nxt.resp_code = ACK_ADDR_ERROR;
			end else if (!req_block_write) begin
				st_nxt.resp_code = ACK_COMPLETE;
			end else if (mgmt_busy) begin
				st_nxt.resp_code = ACK_BUSY_X;
			end else begin
				st_nxt.resp_code      = ACK_COMPLETE;
				st_nxt.fetch_valid    = 1'b1;
				st_nxt.fetch_cmd      = 1'b0;
				st_nxt.fetch_agent    = 2'h0;
				st_nxt.fetch_priority = st_r.fetch_ctl[MGMT_PRI_HI:MGMT_PRI_LO];
				st_nxt.fetch_length   = MGMT_ORB_QUADS;
				// Busy is set by the accept and wins over a host clear
				st_nxt.fetch_ctl[MGMT_BUSY_POS] = 1'b1;
			end
		end

		// Command block agent requests
		if (cmd_req) begin
			st_nxt.resp_valid = 1'b1;
			if (!agent_ok[req_agent]) begin
				st_nxt.resp_code = ACK_ADDR_ERROR;
			end else begin
				st_nxt.resp_code = ACK_COMPLETE;
				if (req_block_write && req_target == TGT_ORB_PTR) begin
					st_nxt.fetch_valid    = 1'b1;
					st_nxt.fetch_cmd      = 1'b1;
					st_nxt.fetch_agent    = req_agent;
					st_nxt.fetch_priority = 4'h0;
					st_nxt.fetch_length   = st_r.fetch_ctl[CMD_LEN_HI:CMD_LEN_LO];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Receive path
	sofc_rx_format u_rx_format (
		.pclk     (pclk),
		.presetn  (presetn),
		.rx_valid (rx_valid),
		.rx_first (rx_first),
		.rx_mgmt  (rx_mgmt),
		.rx_data  (rx_data),
		.short_en (st_r.fetch_ctl[MGMT_SHORT_POS]),
		.mgmt_wr  (mgmt_rx_fifo_wr),
		.cmd_wr   (cmd_rx_fifo_wr),
		.wr_data  (rx_fifo_data)
	);

	// ==========================================================
	// Outputs
	assign prdata         = st_r.prdata;
	assign pready         = st_r.pready;
	assign pslverr        = st_r.pslverr;
	assign resp_valid     = st_r.resp_valid;
	assign resp_code      = st_r.resp_code;
	assign fetch_valid    = st_r.fetch_valid;
	assign fetch_cmd      = st_r.fetch_cmd;
	assign fetch_agent    = st_r.fetch_agent;
	assign fetch_priority = st_r.fetch_priority;
	assign fetch_length   = st_r.fetch_length;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_busy_ack;
		mgmt_req && req_block_write && mgmt_valid && mgmt_busy
			|=> resp_valid && resp_code == ACK_BUSY_X && !fetch_valid;
	endproperty
	a_busy_ack: assert property (p_busy_ack)
		else $error("busy management agent not answered ack_busy_x");

	property p_mgmt_fetch;
		mgmt_req && req_block_write && mgmt_valid && !mgmt_busy
			|=> fetch_valid && !fetch_cmd && fetch_length == MGMT_ORB_QUADS
			&& st_r.fetch_ctl[MGMT_BUSY_POS];
	endproperty
	a_mgmt_fetch: assert property (p_mgmt_fetch)
		else $error("management block write did not start a fetch");

	property p_mgmt_priority;
		mgmt_req && req_block_write && mgmt_valid && !mgmt_busy
			|=> fetch_priority == $past(st_r.fetch_ctl[27:24]);
	endproperty
	a_mgmt_priority: assert property (p_mgmt_priority)
		else $error("management fetch priority wrong");

	property p_mgmt_invalid;
		mgmt_req && !mgmt_valid |=> resp_code == ACK_ADDR_ERROR && !fetch_valid;
	endproperty
	a_mgmt_invalid: assert property (p_mgmt_invalid)
		else $error("invalid management agent accepted a request");

	property p_cmd_fetch;
		cmd_req && req_block_write && req_target == TGT_ORB_PTR && agent_ok[req_agent]
			|=> fetch_valid && fetch_cmd && fetch_agent == $past(req_agent)
			&& fetch_length == $past(st_r.fetch_ctl[23:16]);
	endproperty
	a_cmd_fetch: assert property (p_cmd_fetch)
		else $error("command ORB fetch missing or wrong length");

	property p_unassigned_reject;
		cmd_req && !st_r.assigned[req_agent]
			|=> resp_valid && resp_code == ACK_ADDR_ERROR && !fetch_valid;
	endproperty
	a_unassigned_reject: assert property (p_unassigned_reject)
		else $error("unassigned agent accepted a request");

	property p_agent_invalid;
		cmd_req && !agent_valid[req_agent] |=> resp_code == ACK_ADDR_ERROR;
	endproperty
	a_agent_invalid: assert property (p_agent_invalid)
		else $error("invalid command agent accepted a request");

	property p_bus_reset_keeps;
		bus_reset && !apb_wr && !mgmt_req
			|=> st_r.fetch_ctl == $past(st_r.fetch_ctl) && st_r.assigned == 4'h0;
	endproperty
	a_bus_reset_keeps: assert property (p_bus_reset_keeps)
		else $error("bus reset disturbed fetch control");

	property p_apb_answer;
		apb_setup |=> pready ##1 !pready || (psel && !penable);
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB access phase not one cycle");

endmodule // sofc_fetch_control

// >>> test/sofc_initiator_model.sv
`timescale 1ns/1ps
// ==========================================================
// Remote initiator: answers ORB fetch reads with quadlets
module sofc_initiator_model import sofc_pkg::*; #(
	parameter logic [31:0] QUAD_BASE = 32'hC0DE0000
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Fetch read requests
	input  wire logic        fetch_valid,
	input  wire logic        fetch_cmd,
	input  wire logic [7:0]  fetch_length,
	input  wire logic [3:0]  gap,
	// Fetched quadlet stream
	output logic             rx_valid,
	output logic             rx_first,
	output logic             rx_mgmt,
	output logic [31:0]      rx_data
);
	int left;
	int idx;
	int hold;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left <= 0;
			idx <= 0;
			hold <= 0;
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			rx_mgmt <= 1'b0;
			rx_data <= 32'h0;
		end else begin
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
			// Idle data toggles so a stale word never looks valid
			rx_data <= ~rx_data;
			if (fetch_valid) begin
				left <= 32'(fetch_length);
				idx <= 0;
				hold <= 32'(gap);
				rx_mgmt <= !fetch_cmd;
			end else if (left > 0 && hold > 0) begin
				hold <= hold - 1;
			end else if (left > 0) begin
				rx_valid <= 1'b1;
				rx_first <= (idx == 0);
				rx_data <= QUAD_BASE + 32'(idx);
				idx <= idx + 1;
				left <= left - 1;
				hold <= 32'(gap);
			end
		end
	end
endmodule // sofc_initiator_model

// >>> test/sbp2_agent_fetch_control_test.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the Agent_fetch_control block
module sbp2_agent_fetch_control_test import sofc_pkg::*;;
	localparam logic [31:0] QUAD_BASE = 32'hC0DE0000;
	logic         pclk, presetn, psel, penable, pwrite, bus_reset;
	logic [7:0]   paddr, fetch_length;
	logic [31:0]  pwdata, prdata, rx_data, rx_fifo_data;
	logic         pready, pslverr, req_valid, req_block_write, resp_valid;
	sofc_target_t req_target;
	logic [1:0]   req_agent, fetch_agent;
	logic [15:0]  req_src_id;
	logic [3:0]   resp_code, fetch_priority, gap;
	logic         fetch_valid, fetch_cmd, rx_valid, rx_first, rx_mgmt;
	logic         mgmt_rx_fifo_wr, cmd_rx_fifo_wr;
	logic [32:0]  wq[$];
	int           num_errors, check_count;

	sofc_fetch_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus_reset, .req_valid,
		.req_block_write, .req_target, .req_agent, .req_src_id, .resp_valid,
		.resp_code, .fetch_valid, .fetch_cmd, .fetch_agent, .fetch_priority,
		.fetch_length, .rx_valid, .rx_first, .rx_mgmt, .rx_data,
		.mgmt_rx_fifo_wr, .cmd_rx_fifo_wr, .rx_fifo_data);
	sofc_initiator_model #(.QUAD_BASE(QUAD_BASE)) far (.pclk, .presetn,
		.fetch_valid, .fetch_cmd, .fetch_length, .gap, .rx_valid,
		.rx_first, .rx_mgmt, .rx_data);

	// ==========================================================
	// Clock, monitor, checks
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) if (mgmt_rx_fifo_wr === 1'b1 || cmd_rx_fifo_wr === 1'b1)
		wq.push_back({mgmt_rx_fifo_wr, rx_fifo_data});

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// APB master and remote request drivers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		if (n >= 20) chk("pready", 32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk("prdata", x, q);
		chk("pslverr", 32'(ee), 32'(e));
	endtask
	task automatic req(input logic bw, input sofc_target_t t, input logic [1:0] ag,
			input logic [15:0] id, input logic [3:0] code, input logic f);
		@(posedge pclk);
		req_valid <= 1'b1;
		req_block_write <= bw;
		req_target <= t;
		req_agent <= ag;
		req_src_id <= id;
		@(posedge pclk);
		req_valid <= 1'b0;
		#1;
		chk("resp_valid", 32'h1, 32'(resp_valid));
		chk("resp_code", 32'(code), 32'(resp_code));
		chk("fetch_valid", 32'(f), 32'(fetch_valid));
	endtask
	task automatic drain(input logic m, input int n, input int skip);
		int k;
		k = 0;
		while (wq.size() < n && k < 300) begin
			@(posedge pclk);
			k++;
		end
		repeat (4) @(posedge pclk);
		chk("fifo_writes", 32'(n), 32'(wq.size()));
		for (k = 0; k < wq.size(); k++) begin
			chk("fifo_port", 32'(m), 32'(wq[k][32]));
			chk("fifo_word", QUAD_BASE + 32'(skip + k), wq[k][31:0]);
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rdc(ADDR_FETCH_CTL, 32'h10080F00, 1'b0);
		rdc(ADDR_MGMT_AGT, 32'h00004000, 1'b0);
		rdc(ADDR_CMD_AGT, 32'h0, 1'b0);
		wr(ADDR_FETCH_CTL, 32'hFFFFFFFF);
		rdc(ADDR_FETCH_CTL, 32'hDFFFFFFF, 1'b0);
		rdc(8'h60, 32'h0, 1'b1);
	endtask
	task automatic t_mgmt();
		wr(ADDR_FETCH_CTL, 32'h1508F000);
		req(1'b1, TGT_MGMT, 2'h0, 16'h0, 4'h7, 1'b0);
		wr(ADDR_FETCH_CTL, 32'h9508F000);
		// A plain write to a valid management agent completes without a fetch
		req(1'b0, TGT_MGMT, 2'h0, 16'h0, 4'h1, 1'b0);
		wq.delete();
		req(1'b1, TGT_MGMT, 2'h0, 16'h0, 4'h1, 1'b1);
		chk("fetch_head", 32'h0508, {17'h0, fetch_cmd, fetch_agent,
			fetch_priority, fetch_length});
		drain(1'b1, 5, 3);
		rdc(ADDR_FETCH_CTL, 32'hD508F000, 1'b0);
		req(1'b1, TGT_MGMT, 2'h0, 16'h0, 4'h4, 1'b0);
		// Host clears busy and turns short format off in one write
		wr(ADDR_FETCH_CTL, 32'h8508F000);
		wq.delete();
		req(1'b1, TGT_MGMT, 2'h0, 16'h0, 4'h1, 1'b1);
		drain(1'b1, 8, 0);
		@(posedge pclk);
		bus_reset <= 1'b1;
		@(posedge pclk);
		bus_reset <= 1'b0;
		rdc(ADDR_FETCH_CTL, 32'hC508F000, 1'b0);
		rdc(ADDR_MGMT_AGT, 32'h00004000, 1'b0);
	endtask
	task automatic t_cmd();
		logic [15:0] id;
		for (int a = 0; a < NUM_AGENTS; a++) begin
			id = 16'hFFC0 | 16'(a);
			// Later agents get slower answers from the far side
			gap <= 4'(a);
			// Length 0Ch stays below the command FIFO size
			wr(ADDR_FETCH_CTL, 32'h000C0000 | (32'h8000 >> a));
			req(1'b1, TGT_ORB_PTR, 2'(a), id, 4'h7, 1'b0);
			wr(ADDR_AGT_CTL, {14'h0, 2'(a), id});
			rdc(ADDR_AGT_CTL, 32'((2 << a) - 1), 1'b0);
			req(1'b0, TGT_OTHER, 2'(a), id ^ 16'h1, 4'h7, 1'b0);
			wr(ADDR_FETCH_CTL, 32'h000C0000);
			req(1'b1, TGT_ORB_PTR, 2'(a), id, 4'h7, 1'b0);
			wr(ADDR_FETCH_CTL, 32'h000C0000 | (32'h8000 >> a));
			// Accepted requests that are not pointer block writes fetch nothing
			req(1'b0, TGT_OTHER, 2'(a), id, 4'h1, 1'b0);
			req(1'b0, TGT_ORB_PTR, 2'(a), id, 4'h1, 1'b0);
			wq.delete();
			req(1'b1, TGT_ORB_PTR, 2'(a), id, 4'h1, 1'b1);
			chk("fetch_head", {17'h0, 1'b1, 2'(a), 12'h00C}, {17'h0, fetch_cmd,
				fetch_agent, fetch_priority, fetch_length});
			drain(1'b0, 12, 0);
		end
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		bus_reset = 1'b0;
		req_valid = 1'b0;
		req_block_write = 1'b0;
		req_target = TGT_MGMT;
		req_agent = 2'h0;
		req_src_id = 16'h0;
		gap = 4'h0;
		num_errors = 0;
		check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_mgmt();
		t_cmd();
		close_out();
	end
	initial begin
		repeat (6000) @(posedge pclk);
		num_errors++;
		close_out();
	end
endmodule // sbp2_agent_fetch_control_test
